// ---- rtl/iovfh_top.sv ----
`include "iovfh_defs.svh"

module iovfh_top (
    input  wire logic        clk_sys_in,      // System clock, 50 MHz
    input  wire logic        rst_in,          // Synchronous reset, active high
    input  wire logic [7:0]  cmd_code_in,     // Command code of the access
    input  wire logic        wr_en_in,        // Write strobe, one cycle
    input  wire logic [15:0] wr_data_in,      // Write data, low bits for bytes
    input  wire logic        rd_en_in,        // Read strobe, one cycle
    input  wire logic [15:0] vin_meas_in,     // Measured input voltage
    input  wire logic        unit_tick_in,    // One pulse per delay time unit
    input  wire logic        fault_clear_in,  // Host clears the fault
    input  wire logic        off_cmd_in,      // Converter commanded off
    input  wire logic        other_fault_in,  // Another shutdown fault
    output logic [15:0]      rd_data_out,     // Read data
    output logic             rd_valid_out,    // Read data valid pulse
    output logic             output_en_out,   // Converter output enable
    output logic             ov_fault_out,    // Over-voltage fault level
    output logic             ov_warn_out,     // Over-voltage warning level
    output logic             uv_warn_out,     // Under-voltage warning level
    output logic             ratio_reg_out    // Ratio regulation active
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    iovfh_pkg::iovfh_word_t    ov_fault_lim_r;
    logic [7:0]                ov_reaction_r;
    iovfh_pkg::iovfh_word_t    ov_warn_lim_r;
    iovfh_pkg::iovfh_word_t    uv_warn_lim_r;
    logic [7:0]                vendor_opt_r;
    iovfh_pkg::iovfh_state_e   state_r;
    iovfh_pkg::iovfh_state_e   state_nxt;
    logic [7:0]                unit_cnt_r;
    logic [2:0]                retry_cnt_r;
    logic                      fault_prev_r;
    logic [1:0]                resp;
    logic [2:0]                retry_set;
    logic [2:0]                delay_set;
    logic [8:0]                delay_units;
    logic                      delay_done;
    logic                      fault_now;
    logic                      new_fault;
    logic                      stop_retry;
    logic                      timer_run;

    // Reaction byte fields
    assign resp        = ov_reaction_r[`IOVFH_RESP_MSB:`IOVFH_RESP_LSB];
    assign retry_set   = ov_reaction_r[`IOVFH_RETRY_MSB:`IOVFH_RETRY_LSB];
    assign delay_set   = ov_reaction_r[`IOVFH_DELAY_MSB:`IOVFH_DELAY_LSB];

    // Delay length in time units and its end
    assign delay_units = 9'h001 << delay_set;
    assign delay_done  = unit_tick_in && (({1'b0, unit_cnt_r} + 9'h001) == delay_units);
    assign fault_now   = vin_meas_in > ov_fault_lim_r;
    assign new_fault   = fault_now && !fault_prev_r;
    assign stop_retry  = off_cmd_in || other_fault_in;
    assign timer_run   = (state_r == iovfh_pkg::IOVFH_TOLERATE) || (state_r == iovfh_pkg::IOVFH_RETRY_WAIT);

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Threshold, reaction and option registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ov_fault_lim_r <= `IOVFH_RST_OV_FAULT_LIM;
            ov_reaction_r  <= `IOVFH_RST_OV_REACTION;
            ov_warn_lim_r  <= `IOVFH_RST_OV_WARN_LIM;
            uv_warn_lim_r  <= `IOVFH_RST_UV_WARN_LIM;
            vendor_opt_r   <= `IOVFH_RST_VENDOR_OPT;
        end else if (wr_en_in) begin
            if (cmd_code_in == `IOVFH_CMD_OV_FAULT_LIM) begin
                ov_fault_lim_r <= wr_data_in;
            end else if (cmd_code_in == `IOVFH_CMD_OV_REACTION) begin
                ov_reaction_r <= wr_data_in[7:0];
            end else if (cmd_code_in == `IOVFH_CMD_OV_WARN_LIM) begin
                ov_warn_lim_r <= wr_data_in;
            end else if (cmd_code_in == `IOVFH_CMD_UV_WARN_LIM) begin
                uv_warn_lim_r <= wr_data_in;
            end else if (cmd_code_in == `IOVFH_CMD_VENDOR_OPT) begin
                vendor_opt_r <= wr_data_in[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    // Read data one cycle after the strobe, unmapped codes read zero
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_data_out  <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
            if (!rd_en_in) begin
                rd_data_out <= rd_data_out;
            end else if (cmd_code_in == `IOVFH_CMD_OV_FAULT_LIM) begin
                rd_data_out <= ov_fault_lim_r;
            end else if (cmd_code_in == `IOVFH_CMD_OV_REACTION) begin
                rd_data_out <= {8'h00, ov_reaction_r};
            end else if (cmd_code_in == `IOVFH_CMD_OV_WARN_LIM) begin
                rd_data_out <= ov_warn_lim_r;
            end else if (cmd_code_in == `IOVFH_CMD_UV_WARN_LIM) begin
                rd_data_out <= uv_warn_lim_r;
            end else if (cmd_code_in == `IOVFH_CMD_VENDOR_OPT) begin
                rd_data_out <= {8'h00, vendor_opt_r};
            end else if (cmd_code_in == `IOVFH_CMD_STATUS) begin
                rd_data_out <= {5'h00, state_r, retry_cnt_r, output_en_out,
                                ov_fault_out, ov_warn_out, uv_warn_out, ratio_reg_out};
            end else begin
                rd_data_out <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Threshold comparators
    // ------------------------------------------------------------------------
    // Registered fault, warning and ratio regulation flags
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ov_fault_out  <= 1'b0;
            ov_warn_out   <= 1'b0;
            uv_warn_out   <= 1'b0;
            ratio_reg_out <= 1'b0;
            fault_prev_r  <= 1'b0;
        end else begin
            ov_fault_out  <= fault_now;
            ov_warn_out   <= vin_meas_in > ov_warn_lim_r;
            uv_warn_out   <= vin_meas_in < uv_warn_lim_r;
            ratio_reg_out <= vendor_opt_r[`IOVFH_OPT_RATIO_BIT] &&
                             (vin_meas_in < uv_warn_lim_r);
            fault_prev_r  <= fault_now;
        end
    end

    // ------------------------------------------------------------------------
    // Fault response state machine
    // ------------------------------------------------------------------------
    // Next state from response, retry setting and delay timer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            iovfh_pkg::IOVFH_RUN: begin
                if (fault_now) begin
                    case (resp)
                        `IOVFH_RESP_IGNORE:   state_nxt = iovfh_pkg::IOVFH_RUN;
                        `IOVFH_RESP_TOLERATE: state_nxt = iovfh_pkg::IOVFH_TOLERATE;
                        `IOVFH_RESP_DISABLE: begin
                            if (retry_set == `IOVFH_RETRY_NONE) begin
                                state_nxt = iovfh_pkg::IOVFH_LATCHED_OFF;
                            end else begin
                                state_nxt = iovfh_pkg::IOVFH_RETRY_WAIT;
                            end
                        end
                        default:              state_nxt = iovfh_pkg::IOVFH_HOLD_OFF;
                    endcase
                end
            end
            iovfh_pkg::IOVFH_TOLERATE: begin
                if (!fault_now) begin
                    state_nxt = iovfh_pkg::IOVFH_RUN;
                end else if (delay_done) begin
                    if (retry_set == `IOVFH_RETRY_NONE) begin
                        state_nxt = iovfh_pkg::IOVFH_LATCHED_OFF;
                    end else begin
                        state_nxt = iovfh_pkg::IOVFH_RETRY_WAIT;
                    end
                end
            end
            iovfh_pkg::IOVFH_RETRY_WAIT: begin
                if (retry_set == `IOVFH_RETRY_ENDLESS && stop_retry) begin
                    state_nxt = iovfh_pkg::IOVFH_LATCHED_OFF;
                end else if (delay_done) begin
                    if (!fault_now) begin
                        state_nxt = iovfh_pkg::IOVFH_RUN;
                    end else if (retry_set != `IOVFH_RETRY_ENDLESS &&
                                 (retry_cnt_r + 3'h1) >= retry_set) begin
                        state_nxt = iovfh_pkg::IOVFH_LATCHED_OFF;
                    end
                end
            end
            iovfh_pkg::IOVFH_HOLD_OFF: begin
                if (!fault_now) begin
                    state_nxt = iovfh_pkg::IOVFH_RUN;
                end
            end
            default: begin
                state_nxt = iovfh_pkg::IOVFH_LATCHED_OFF;
            end
        endcase
        if (fault_clear_in) begin
            state_nxt = iovfh_pkg::IOVFH_RUN;
        end
    end

    // State register and output enable
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r       <= iovfh_pkg::IOVFH_RUN;
            output_en_out <= 1'b1;
        end else begin
            state_r       <= state_nxt;
            output_en_out <= (state_nxt == iovfh_pkg::IOVFH_RUN) ||
                             (state_nxt == iovfh_pkg::IOVFH_TOLERATE);
        end
    end

    // ------------------------------------------------------------------------
    // Delay timer and retry counter
    // ------------------------------------------------------------------------
    // Time unit counter, restarted on a new fault, clear or each attempt
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            unit_cnt_r <= 8'h00;
        end else if (fault_clear_in || new_fault || !timer_run || delay_done) begin
            unit_cnt_r <= 8'h00;
        end else if (unit_tick_in) begin
            unit_cnt_r <= unit_cnt_r + 8'h01;
        end
    end

    // Failed attempts since the fault began
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            retry_cnt_r <= 3'h0;
        end else if (fault_clear_in || state_r == iovfh_pkg::IOVFH_RUN) begin
            retry_cnt_r <= 3'h0;
        end else if (state_r == iovfh_pkg::IOVFH_RETRY_WAIT && delay_done && fault_now &&
                     retry_cnt_r != 3'h7) begin
            retry_cnt_r <= retry_cnt_r + 3'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_fault_lim_write;
        wr_en_in && cmd_code_in == `IOVFH_CMD_OV_FAULT_LIM |=> ov_fault_lim_r == $past(wr_data_in);
    endproperty
    a_fault_lim_write: assert property (p_fault_lim_write) else $error("fault limit not written");

    property p_ignore;
        state_r == iovfh_pkg::IOVFH_RUN && resp == `IOVFH_RESP_IGNORE && !fault_clear_in
        |=> state_r == iovfh_pkg::IOVFH_RUN && output_en_out;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore response left run");

    property p_tolerate_run;
        state_r == iovfh_pkg::IOVFH_TOLERATE |-> output_en_out;
    endproperty
    a_tolerate_run: assert property (p_tolerate_run) else $error("output off while tolerating");

    property p_disable_now;
        state_r == iovfh_pkg::IOVFH_RUN && fault_now && resp == `IOVFH_RESP_DISABLE && !fault_clear_in
        |=> !output_en_out ##0 state_r != iovfh_pkg::IOVFH_RUN;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("disable response kept output on");

    property p_resume;
        state_r == iovfh_pkg::IOVFH_HOLD_OFF && !fault_now |=> output_en_out;
    endproperty
    a_resume: assert property (p_resume) else $error("output not resumed");

    property p_latched;
        state_r == iovfh_pkg::IOVFH_LATCHED_OFF && !fault_clear_in
        |=> state_r == iovfh_pkg::IOVFH_LATCHED_OFF ##0 !output_en_out;
    endproperty
    a_latched: assert property (p_latched) else $error("latched off left without clear");

    property p_retry_limit;
        retry_set != `IOVFH_RETRY_ENDLESS && !$changed(ov_reaction_r)
        |-> retry_cnt_r < retry_set || retry_set == 3'h0 || state_r != iovfh_pkg::IOVFH_RETRY_WAIT;
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("too many restart attempts");

    property p_endless_stop;
        state_r == iovfh_pkg::IOVFH_RETRY_WAIT && retry_set == `IOVFH_RETRY_ENDLESS && stop_retry && !fault_clear_in
        |=> state_r == iovfh_pkg::IOVFH_LATCHED_OFF;
    endproperty
    a_endless_stop: assert property (p_endless_stop) else $error("endless retry not stopped");

    property p_delay_bound;
        timer_run |-> ({1'b0, unit_cnt_r} < delay_units) || $changed(ov_reaction_r);
    endproperty
    a_delay_bound: assert property (p_delay_bound) else $error("delay counter overran");

    property p_ratio;
        ratio_reg_out |-> $past(vendor_opt_r[`IOVFH_OPT_RATIO_BIT]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio regulation without enable");

    property p_clear;
        fault_clear_in |=> state_r == iovfh_pkg::IOVFH_RUN && retry_cnt_r == 3'h0 && unit_cnt_r == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not restart");

    c_tolerate:  cover property (state_r == iovfh_pkg::IOVFH_TOLERATE ##1 state_r == iovfh_pkg::IOVFH_RETRY_WAIT);
    c_recover:   cover property (state_r == iovfh_pkg::IOVFH_RETRY_WAIT ##1 state_r == iovfh_pkg::IOVFH_RUN);
    c_give_up:   cover property (state_r == iovfh_pkg::IOVFH_RETRY_WAIT ##1 state_r == iovfh_pkg::IOVFH_LATCHED_OFF);
    c_hold:      cover property (state_r == iovfh_pkg::IOVFH_HOLD_OFF ##1 state_r == iovfh_pkg::IOVFH_RUN);

endmodule // iovfh_top

// ---- rtl/iovfh_defs.svh ----
`ifndef IOVFH_DEFS_SVH
`define IOVFH_DEFS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define IOVFH_CMD_OV_FAULT_LIM   8'h55
`define IOVFH_CMD_OV_REACTION    8'h56
`define IOVFH_CMD_OV_WARN_LIM    8'h57
`define IOVFH_CMD_UV_WARN_LIM    8'h58
`define IOVFH_CMD_VENDOR_OPT     8'hE0
`define IOVFH_CMD_STATUS         8'hE8

// ----------------------------------------------------------------------------
// Field positions of the reaction byte and option byte
// ----------------------------------------------------------------------------
`define IOVFH_RESP_MSB           7
`define IOVFH_RESP_LSB           6
`define IOVFH_RETRY_MSB          5
`define IOVFH_RETRY_LSB          3
`define IOVFH_DELAY_MSB          2
`define IOVFH_DELAY_LSB          0
`define IOVFH_OPT_RATIO_BIT      0

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define IOVFH_RESP_IGNORE        2'h0
`define IOVFH_RESP_TOLERATE      2'h1
`define IOVFH_RESP_DISABLE       2'h2
`define IOVFH_RESP_RESUME        2'h3
`define IOVFH_RETRY_NONE         3'h0
`define IOVFH_RETRY_ENDLESS      3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IOVFH_RST_OV_FAULT_LIM   16'hFFFF
`define IOVFH_RST_OV_REACTION    8'h80
`define IOVFH_RST_OV_WARN_LIM    16'hFFFF
`define IOVFH_RST_UV_WARN_LIM    16'h0000
`define IOVFH_RST_VENDOR_OPT     8'h00

`endif

// ---- rtl/iovfh_pkg.sv ----
package iovfh_pkg;

    // ------------------------------------------------------------------------
    // Fault response state machine
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        IOVFH_RUN,
        IOVFH_TOLERATE,
        IOVFH_RETRY_WAIT,
        IOVFH_HOLD_OFF,
        IOVFH_LATCHED_OFF
    } iovfh_state_e;

    typedef logic [15:0] iovfh_word_t;

endpackage : iovfh_pkg

// ---- sim/iovfh_host_model.sv ----
module iovfh_host_model (
    input  wire logic        clk_in,        // System clock
    output logic [7:0]       cmd_code_out,  // Command code
    output logic             wr_en_out,     // Write strobe
    output logic [15:0]      wr_data_out,   // Write data
    output logic             rd_en_out,     // Read strobe
    input  wire logic [15:0] rd_data_in,    // Read data
    input  wire logic        rd_valid_in    // Read data valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle at time zero
    initial begin
        cmd_code_out = 8'h00;
        wr_en_out    = 1'b0;
        wr_data_out  = 16'h0000;
        rd_en_out    = 1'b0;
    end

    // Write: strobe for one edge, then data scrambled so stale data never looks valid
    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk_in);
        cmd_code_out <= code;
        wr_data_out  <= data;
        wr_en_out    <= 1'b1;
        @(posedge clk_in);
        wr_en_out    <= 1'b0;
        wr_data_out  <= ~data;
    endtask

    // Read: answer is taken mid-cycle, once settled after the edge that samples the strobe
    task automatic read_reg(input logic [7:0] code, output logic [15:0] data, output logic valid);
        @(posedge clk_in);
        cmd_code_out <= code;
        rd_en_out    <= 1'b1;
        @(posedge clk_in);
        rd_en_out    <= 1'b0;
        @(negedge clk_in);
        valid = rd_valid_in;
        data  = rd_data_in;
    endtask
endmodule // iovfh_host_model

// ---- sim/iovfh_top_tb.sv ----
module iovfh_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_in;
    logic        rst_in;
    logic [7:0]  cmd_code;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        rd_en;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [15:0] vin;
    logic        tick_r;
    logic [2:0]  ctl;
    logic        output_en;
    logic        ov_fault;
    logic        ov_warn;
    logic        uv_warn;
    logic        ratio;
    int          fails;
    int          num_checks;

    // Clock source, 20 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    iovfh_host_model host (.clk_in(clk_sys_in), .cmd_code_out(cmd_code), .wr_en_out(wr_en),
        .wr_data_out(wr_data), .rd_en_out(rd_en), .rd_data_in(rd_data), .rd_valid_in(rd_valid));

    iovfh_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_code_in(cmd_code), .wr_en_in(wr_en),
        .wr_data_in(wr_data), .rd_en_in(rd_en), .vin_meas_in(vin), .unit_tick_in(tick_r),
        .fault_clear_in(ctl[0]), .off_cmd_in(ctl[1]), .other_fault_in(ctl[2]), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .output_en_out(output_en), .ov_fault_out(ov_fault),
        .ov_warn_out(ov_warn), .uv_warn_out(uv_warn), .ratio_reg_out(ratio));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        num_checks++;
        if (seen !== expd) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] expd);
        logic [15:0] d;
        logic        v;
        host.read_reg(code, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, expd);
    endtask

    task automatic en_is(input logic e);
        check({15'h0000, output_en}, {15'h0000, e});
    endtask

    // Input voltage step, then time for flag and state to land
    task automatic set_vin(input logic [15:0] v);
        @(posedge clk_sys_in);
        vin <= v;
        cyc(3);
    endtask

    // Delay time units, one-cycle pulses with a gap
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            tick_r <= 1'b1;
            @(posedge clk_sys_in);
            tick_r <= 1'b0;
        end
        cyc(3);
    endtask

    // Pulse on clear (bit 0), off command (bit 1) or other fault (bit 2)
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_sys_in);
        ctl <= m;
        @(posedge clk_sys_in);
        ctl <= 3'h0;
        cyc(3);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        cyc(20000);
        fails++;
        wrap_up();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        vin    = 16'h0800;
        tick_r = 1'b0;
        ctl    = 3'h0;
        cyc(5);
        rst_in <= 1'b0;
        rd_chk(8'h55, 16'hFFFF);
        rd_chk(8'h56, 16'h0080);
        rd_chk(8'h57, 16'hFFFF);
        rd_chk(8'h58, 16'h0000);
        host.write_reg(8'h5B, 16'h1234);
        rd_chk(8'h5B, 16'h0000); // unmapped code reads zero
        host.write_reg(8'h55, 16'h1000);
        host.write_reg(8'h56, 16'hABC2);
        host.write_reg(8'h57, 16'h0C00);
        host.write_reg(8'h58, 16'h0400);
        rd_chk(8'h55, 16'h1000);
        rd_chk(8'h56, 16'h00C2);
        rd_chk(8'h57, 16'h0C00);
        rd_chk(8'h58, 16'h0400);
        $display("test registers done");
        host.write_reg(8'h56, 16'h0000);
        set_vin(16'h0C01);
        check({14'h0000, ov_fault, ov_warn}, 16'h0001);
        set_vin(16'h1000);
        check({14'h0000, ov_fault, ov_warn}, 16'h0001);
        set_vin(16'h1001);
        check({14'h0000, ov_fault, ov_warn}, 16'h0003);
        tick(4);
        en_is(1'b1);
        set_vin(16'h03FF);
        check({14'h0000, uv_warn, ratio}, 16'h0002);
        host.write_reg(8'hE0, 16'h0001);
        cyc(3);
        check({14'h0000, uv_warn, ratio}, 16'h0003);
        set_vin(16'h0400);
        check({14'h0000, uv_warn, ratio}, 16'h0000);
        host.write_reg(8'hE0, 16'h0000);
        $display("test flags done");
        host.write_reg(8'h56, 16'h00C0);
        set_vin(16'h2000);
        tick(3);
        en_is(1'b0);
        set_vin(16'h0800);
        en_is(1'b1);
        for (int d = 0; d < 4; d++) begin
            host.write_reg(8'h56, {8'h00, 2'b10, 3'b001, d[2:0]});
            set_vin(16'h2000);
            en_is(1'b0);
            set_vin(16'h0800);
            tick((1 << d) - 1);
            en_is(1'b0);
            tick(1);
            en_is(1'b1);
        end
        host.write_reg(8'h56, 16'h0080);
        set_vin(16'h2000);
        set_vin(16'h0800);
        tick(4);
        en_is(1'b0);
        pulse(3'b001);
        en_is(1'b1);
        $display("test disable and spacing done");
        for (int n = 1; n < 7; n++) begin
            host.write_reg(8'h56, {8'h00, 2'b10, n[2:0], 3'b000});
            set_vin(16'h2000);
            tick(n - 1);
            set_vin(16'h0800);
            tick(1);
            en_is(1'b1);
            set_vin(16'h2000);
            tick(n);
            set_vin(16'h0800);
            tick(1);
            en_is(1'b0);
            pulse(3'b001);
        end
        host.write_reg(8'h56, 16'h0041);
        set_vin(16'h2000);
        tick(1);
        en_is(1'b1);
        tick(1);
        en_is(1'b0);
        set_vin(16'h0800);
        tick(2);
        en_is(1'b0);
        rd_chk(8'hE8, 16'h0400);
        pulse(3'b001);
        $display("test retry counts done");
        host.write_reg(8'h56, 16'h00B8);
        for (int k = 1; k < 3; k++) begin
            set_vin(16'h2000);
            tick(9);
            rd_chk(8'hE8, 16'h02EC);
            set_vin(16'h0800);
            tick(1);
            en_is(1'b1);
            set_vin(16'h2000);
            pulse(3'(1 << k));
            set_vin(16'h0800);
            tick(2);
            en_is(1'b0);
            pulse(3'b001);
        end
        $display("test endless retry done");
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        rd_chk(8'h55, 16'hFFFF);
        rd_chk(8'hE8, 16'h0010);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule // iovfh_top_tb
